/* File: iepc_pkg.sv */
// Constants for the edge and priority interrupt controller.
package iepc_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned NUM_SRC  = 16;
	localparam int unsigned SRC_W    = 4;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_SYSTEM_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_PRIORITY_SELECT_A = 8'h01;
	localparam logic [7:0] OFS_PRIORITY_SELECT_B = 8'h02;
	localparam logic [7:0] OFS_EVENT_STATUS      = 8'h03;
	localparam logic [7:0] OFS_EVENT_MASK        = 8'h04;
	localparam logic [7:0] OFS_REQUEST_STATE     = 8'h05;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned BIT_USER_BIT_ENABLE         = 3;
	localparam int unsigned BIT_NONMASKABLE_EDGE_SELECT = 2;
	localparam int unsigned BIT_EV_NMI_EDGE             = 0;
	localparam int unsigned BIT_EV_REQ_TAKEN            = 1;
	localparam int unsigned EV_W                        = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SYSTEM_CONTROL    = 8'h09;
	localparam logic [7:0] RST_PRIORITY_SELECT_A = 8'h00;
	localparam logic [7:0] RST_PRIORITY_SELECT_B = 8'h00;
	localparam logic [1:0] RST_EVENT_MASK        = 2'h0;

endpackage : iepc_pkg

/* File: iepc_edge_det.sv */
// Selectable edge detector for the nonmaskable input.
`timescale 1ns/1ps
module iepc_edge_det (
	input  wire logic clk_i,     // System clock
	input  wire logic rst_n_i,   // Synchronised reset, active low
	input  wire logic level_i,   // Sampled input level
	input  wire logic rise_sel_i,// 1 rising, 0 falling
	output logic      pulse_o    // One pulse per selected edge
);

	logic prev_r;
	logic primed_r;

	// ------------------------------------------------------------
	// Sample history
	// ------------------------------------------------------------
	// First sample after reset only primes the history
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_r   <= 1'b0;
			primed_r <= 1'b0;
		end else begin
			prev_r   <= level_i;                                  // [R9]
			primed_r <= 1'b1;
		end
	end

	always_comb begin
		if (rise_sel_i) begin
			pulse_o = primed_r & ~prev_r & level_i;             // [R4] [R9]
		end else begin
			pulse_o = primed_r & prev_r & ~level_i;             // [R3] [R9]
		end
	end

endmodule : iepc_edge_det

/* File: iepc_ctrl.sv */
// Interrupt controller: mask-bit mode, nonmaskable edge and two priority levels.
//
// Notes on behaviour
// R1: user_bit_enable 0: secondary bit masks interrupts
// R2: user_bit_enable 1: secondary bit ignored
// R3: edge select 0 (reset): falling edge requests
// R4: edge select 1: rising edge requests
// R5: two 8-bit read/write priority registers
// R6: each priority bit sets its group's level
// R7: maskable sources get one of two levels
// R8: nonmaskable always accepted, outranks everything
// R9: edge found by comparing consecutive clock samples
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module iepc_ctrl (
	input  wire logic                            core_clk_i,     // System clock, 200 MHz
	input  wire logic                            arst_n_i,       // Async reset, active low
	input  wire logic [iepc_pkg::ADDR_W-1:0]     reg_addr_i,     // Register address
	input  wire logic [iepc_pkg::DATA_W-1:0]     reg_wdata_i,    // Write data
	input  wire logic                            reg_wr_i,       // Write strobe
	input  wire logic                            reg_rd_i,       // Read strobe
	output logic      [iepc_pkg::DATA_W-1:0]     reg_rdata_o,    // Read data, cycle after strobe
	input  wire logic                            nmi_i,          // Nonmaskable input level
	input  wire logic [iepc_pkg::NUM_SRC-1:0]    src_req_i,      // Maskable source levels
	input  wire logic                            cpu_mask_i,     // Main mask bit of CPU
	input  wire logic                            cpu_sec_bit_i,  // secondary_mask_or_user_bit
	input  wire logic                            cpu_ack_i,      // CPU takes shown request
	output logic                                 req_valid_o,    // Request to CPU
	output logic                                 req_nmi_o,      // Request is the nonmaskable one
	output logic      [iepc_pkg::SRC_W-1:0]      req_src_o,      // Maskable source number
	output logic                                 req_level_o,    // Level of maskable request
	output logic                                 nmi_pulse_o,    // One pulse per nonmaskable edge
	output logic                                 irq_o           // Event interrupt, level
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                            rst_meta_r;
	logic                            rst_n;
	logic [7:0]                      system_control_r;
	logic [7:0]                      priority_select_a_r;
	logic [7:0]                      priority_select_b_r;
	logic [iepc_pkg::EV_W-1:0]       ev_status_r;
	logic [iepc_pkg::EV_W-1:0]       ev_mask_r;
	logic [iepc_pkg::EV_W-1:0]       ev_set;
	logic                            nmi_edge;
	logic                            nmi_pend_r;
	logic                            user_bit_enable;
	logic                            nonmaskable_edge_select;
	logic [iepc_pkg::NUM_SRC-1:0]    src_level;
	logic [iepc_pkg::NUM_SRC-1:0]    src_allowed;
	logic                            pick_valid;
	logic [iepc_pkg::SRC_W-1:0]      pick_src;
	logic                            pick_level;
	logic                            ack_taken;
	logic                            wr_sys;
	logic                            wr_pa;
	logic                            wr_pb;
	logic                            wr_st;
	logic                            wr_mk;
	logic                            nmi_show;
	logic                            req_valid_nxt;
	logic                            req_nmi_nxt;
	logic [iepc_pkg::SRC_W-1:0]      req_src_nxt;
	logic                            req_level_nxt;
	logic [iepc_pkg::EV_W-1:0]       ev_status_nxt;
	logic [iepc_pkg::DATA_W-1:0]     rdata_nxt;

	// Address match, used by every write decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Applied at once, lifted two edges after the pin to avoid a split release
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	assign wr_sys = reg_wr_i & hit(reg_addr_i, iepc_pkg::OFS_SYSTEM_CONTROL);
	assign wr_pa  = reg_wr_i & hit(reg_addr_i, iepc_pkg::OFS_PRIORITY_SELECT_A);
	assign wr_pb  = reg_wr_i & hit(reg_addr_i, iepc_pkg::OFS_PRIORITY_SELECT_B);
	assign wr_st  = reg_wr_i & hit(reg_addr_i, iepc_pkg::OFS_EVENT_STATUS);
	assign wr_mk  = reg_wr_i & hit(reg_addr_i, iepc_pkg::OFS_EVENT_MASK);

	// Bits other than the two controls are stored and read back only
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			system_control_r <= iepc_pkg::RST_SYSTEM_CONTROL;
		end else if (wr_sys) begin
			system_control_r <= reg_wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			priority_select_a_r <= iepc_pkg::RST_PRIORITY_SELECT_A;
			priority_select_b_r <= iepc_pkg::RST_PRIORITY_SELECT_B;
		end else begin
			if (wr_pa) begin
				priority_select_a_r <= reg_wdata_i;                 // [R5] [R6]
			end
			if (wr_pb) begin
				priority_select_b_r <= reg_wdata_i;                 // [R5]
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ev_mask_r <= iepc_pkg::RST_EVENT_MASK;
		end else if (wr_mk) begin
			ev_mask_r <= reg_wdata_i[iepc_pkg::EV_W-1:0];
		end
	end

	assign user_bit_enable         = system_control_r[iepc_pkg::BIT_USER_BIT_ENABLE];
	assign nonmaskable_edge_select = system_control_r[iepc_pkg::BIT_NONMASKABLE_EDGE_SELECT];

	// ------------------------------------------------------------
	// Nonmaskable edge
	// ------------------------------------------------------------
	iepc_edge_det u_nmi_edge (
		.clk_i      (core_clk_i),
		.rst_n_i    (rst_n),
		.level_i    (nmi_i),
		.rise_sel_i (nonmaskable_edge_select),
		.pulse_o    (nmi_edge)
	);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			nmi_pulse_o <= 1'b0;
		end else begin
			nmi_pulse_o <= nmi_edge;                                 // [R9]
		end
	end

	// A take counts only while a request is shown
	assign ack_taken = cpu_ack_i & req_valid_o;

	// Pending until the CPU takes it; a new edge wins over the take
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			nmi_pend_r <= 1'b0;
		end else if (nmi_edge) begin
			nmi_pend_r <= 1'b1;                                      // [R8]
		end else if (ack_taken && req_nmi_o) begin
			nmi_pend_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Priority and masking
	// ------------------------------------------------------------
	// Sources 0..7 follow select A bits, 8..15 select B bits
	assign src_level = {priority_select_b_r, priority_select_a_r};   // [R6] [R7]

	// Main mask blocks all; secondary bit as mask leaves only level 1
	generate
		for (genvar g = 0; g < iepc_pkg::NUM_SRC; g++) begin : g_allow
			always_comb begin
				if (cpu_mask_i) begin
					src_allowed[g] = 1'b0;
				end else if (!user_bit_enable && cpu_sec_bit_i) begin
					src_allowed[g] = src_req_i[g] & src_level[g];  // [R1]
				end else begin
					src_allowed[g] = src_req_i[g];                 // [R1] [R2]
				end
			end
		end
	endgenerate

	// Level 1 first, then lowest source number
	always_comb begin
		pick_valid = 1'b0;
		pick_src   = '0;
		pick_level = 1'b0;
		for (int i = iepc_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (src_allowed[i] && !src_level[i] && !(pick_valid && pick_level)) begin
				pick_valid = 1'b1;
				pick_src   = i[iepc_pkg::SRC_W-1:0];
				pick_level = 1'b0;                                  // [R7]
			end
		end
		for (int i = iepc_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (src_allowed[i] && src_level[i]) begin
				pick_valid = 1'b1;
				pick_src   = i[iepc_pkg::SRC_W-1:0];
				pick_level = 1'b1;                                  // [R7]
			end
		end
	end

	// Nonmaskable ignores both mask bits and priority
	assign nmi_show = nmi_edge | (nmi_pend_r & ~(ack_taken & req_nmi_o));  // [R8]

	always_comb begin
		if (nmi_show) begin
			req_valid_nxt = 1'b1;                                    // [R8]
			req_nmi_nxt   = 1'b1;
			req_src_nxt   = '0;
			req_level_nxt = 1'b0;
		end else begin
			req_valid_nxt = pick_valid;
			req_nmi_nxt   = 1'b0;
			req_src_nxt   = pick_src;
			req_level_nxt = pick_level;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			req_valid_o <= 1'b0;
			req_nmi_o   <= 1'b0;
			req_src_o   <= '0;
			req_level_o <= 1'b0;
		end else begin
			req_valid_o <= req_valid_nxt;
			req_nmi_o   <= req_nmi_nxt;
			req_src_o   <= req_src_nxt;
			req_level_o <= req_level_nxt;
		end
	end

	// ------------------------------------------------------------
	// Event status and interrupt
	// ------------------------------------------------------------
	always_comb begin
		ev_set                                  = '0;
		ev_set[iepc_pkg::BIT_EV_NMI_EDGE]  = nmi_edge;
		ev_set[iepc_pkg::BIT_EV_REQ_TAKEN] = ack_taken;
	end

	// Write one clears; a new event in the same cycle wins
	generate
		for (genvar e = 0; e < iepc_pkg::EV_W; e++) begin : g_event
			always_comb begin
				if (ev_set[e]) begin
					ev_status_nxt[e] = 1'b1;
				end else if (wr_st && reg_wdata_i[e]) begin
					ev_status_nxt[e] = 1'b0;
				end else begin
					ev_status_nxt[e] = ev_status_r[e];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ev_status_r <= '0;
		end else begin
			ev_status_r <= ev_status_nxt;
		end
	end

	// Follows the status bits in the same cycle that they change
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(ev_status_nxt & ev_mask_r);
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Idle cycles return zero, so read data can be OR-ed onto a shared bus
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				iepc_pkg::OFS_SYSTEM_CONTROL:    rdata_nxt = system_control_r;
				iepc_pkg::OFS_PRIORITY_SELECT_A: rdata_nxt = priority_select_a_r; // [R5]
				iepc_pkg::OFS_PRIORITY_SELECT_B: rdata_nxt = priority_select_b_r; // [R5]
				iepc_pkg::OFS_EVENT_STATUS:      rdata_nxt = {6'h00, ev_status_r};
				iepc_pkg::OFS_EVENT_MASK:        rdata_nxt = {6'h00, ev_mask_r};
				iepc_pkg::OFS_REQUEST_STATE:     rdata_nxt = {1'b0, nmi_pend_r, req_level_o,
					req_nmi_o, req_src_o};
				default:                         rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= rdata_nxt;
		end
	end

endmodule : iepc_ctrl

/* File: iepc_cpu_model.sv */
// Behavioural model of the CPU core that takes the shown requests.
`timescale 1ns/1ps
module iepc_cpu_model (
	input  wire logic       clk_i,       // System clock
	input  wire logic       rst_n_i,     // Reset, active low
	input  wire logic       req_valid_i, // Request shown by the controller
	input  wire logic       ack_en_i,    // Take requests at all
	input  wire logic [3:0] wait_i,      // Cycles to wait before taking
	output logic            ack_o        // One-cycle take pulse
);
	logic [3:0] cnt_r;

	// Take pulse drops after one cycle, so one request gets one take
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r <= 4'h0;
			ack_o <= 1'b0;
		end else if (ack_o || !(req_valid_i && ack_en_i)) begin
			cnt_r <= 4'h0;
			ack_o <= 1'b0;
		end else if (cnt_r >= wait_i) begin
			ack_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule : iepc_cpu_model

/* File: iepc_ctrl_checker.sv */
// Port assertions for the edge and priority interrupt controller.
`timescale 1ns/1ps
module iepc_ctrl_checker (
	input wire logic        core_clk_i,    // Clock
	input wire logic        arst_n_i,      // Reset
	input wire logic [7:0]  reg_addr_i,    // Address
	input wire logic [7:0]  reg_wdata_i,   // Write data
	input wire logic        reg_wr_i,      // Write strobe
	input wire logic        reg_rd_i,      // Read strobe
	input wire logic [7:0]  reg_rdata_o,   // Read data
	input wire logic        nmi_i,         // Nonmaskable input
	input wire logic [15:0] src_req_i,     // Sources
	input wire logic        cpu_mask_i,    // Main mask
	input wire logic        cpu_sec_bit_i, // Secondary bit
	input wire logic        cpu_ack_i,     // Take pulse
	input wire logic        req_valid_o,   // Request
	input wire logic        req_nmi_o,     // Nonmaskable shown
	input wire logic [3:0]  req_src_o,     // Source number
	input wire logic        req_level_o,   // Level
	input wire logic        nmi_pulse_o,   // Edge pulse
	input wire logic        irq_o          // Event interrupt
);
	logic [2:0]  age_r;
	logic        ue_r;
	logic        sel_r;
	logic [15:0] prio_r;
	logic [15:0] prio_d_r;
	logic [15:0] src_d_r;

	// ------------------------------------------------------------
	// Shadow of the control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			age_r    <= 3'h0;
			ue_r     <= 1'b1;
			sel_r    <= 1'b0;
			prio_r   <= 16'h0000;
			prio_d_r <= 16'h0000;
			src_d_r  <= 16'h0000;
		end else begin
			age_r    <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
			prio_d_r <= prio_r;
			src_d_r  <= src_req_i;
			if (reg_wr_i && reg_addr_i == 8'h00) begin
				ue_r  <= reg_wdata_i[3];
				sel_r <= reg_wdata_i[2];
			end
			if (reg_wr_i && reg_addr_i == 8'h01) prio_r[7:0] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h02) prio_r[15:8] <= reg_wdata_i;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	a_prio_read: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h01
		|-> reg_rdata_o == $past(prio_r[7:0])) else $error("priority read wrong");
	a_fall_edge: assert property (age_r == 3'h7 && $past(nmi_i, 2) && !$past(nmi_i)
		&& !$past(sel_r) |-> nmi_pulse_o) else $error("falling edge missed");
	a_rise_edge: assert property (age_r == 3'h7 && !$past(nmi_i, 2) && $past(nmi_i)
		&& $past(sel_r) |-> nmi_pulse_o) else $error("rising edge missed");
	a_pulse_cause: assert property (nmi_pulse_o |-> $past(nmi_i) != $past(nmi_i, 2))
		else $error("pulse without edge");
	a_pulse_single: assert property (nmi_pulse_o |=> !nmi_pulse_o)
		else $error("pulse too long");
	a_nmi_shown: assert property (nmi_pulse_o |-> req_valid_o && req_nmi_o)
		else $error("nonmaskable not shown");
	a_nmi_holds: assert property (req_nmi_o && !cpu_ack_i |=> req_nmi_o)
		else $error("nonmaskable dropped");
	a_mask_bits: assert property (req_valid_o && !req_nmi_o |-> !$past(cpu_mask_i)
		&& ($past(ue_r) || !$past(cpu_sec_bit_i) || req_level_o)) else $error("mask ignored");
	a_level_map: assert property (req_valid_o && !req_nmi_o
		|-> req_level_o == prio_d_r[req_src_o] && src_d_r[req_src_o]) else $error("bad level");
	a_level_first: assert property (req_valid_o && !req_nmi_o && !req_level_o
		|-> (src_d_r & prio_d_r) == 16'h0000) else $error("level order wrong");
endmodule : iepc_ctrl_checker

bind iepc_ctrl iepc_ctrl_checker u_chk (.*);

/* File: iepc_ctrl_bench.sv */
// Self-checking bench for the edge and priority interrupt controller.
`timescale 1ns/1ps
module iepc_ctrl_bench;
	logic        core_clk_i    = 1'b0;
	logic        arst_n_i      = 1'b0;
	logic [7:0]  reg_addr_i    = 8'h00;
	logic [7:0]  reg_wdata_i   = 8'h00;
	logic        reg_wr_i      = 1'b0;
	logic        reg_rd_i      = 1'b0;
	logic        nmi_i         = 1'b1;
	logic [15:0] src_req_i     = 16'h0000;
	logic        cpu_mask_i    = 1'b0;
	logic        cpu_sec_bit_i = 1'b0;
	logic        ack_en        = 1'b0;
	logic [3:0]  ack_wait      = 4'h3;
	logic [7:0]  reg_rdata_o;
	logic        cpu_ack_i;
	logic        req_valid_o;
	logic        req_nmi_o;
	logic [3:0]  req_src_o;
	logic        req_level_o;
	logic        nmi_pulse_o;
	logic        irq_o;
	logic [7:0]  pat [2] = '{8'h5a, 8'h81};
	int          n_mismatch = 0;
	int          compares   = 0;

	iepc_ctrl uut (.*);
	iepc_cpu_model cpu (.clk_i(core_clk_i), .rst_n_i(arst_n_i), .req_valid_i(req_valid_o),
		.ack_en_i(ack_en), .wait_i(ack_wait), .ack_o(cpu_ack_i));

	initial begin
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk({8'h00, reg_rdata_o}, {8'h00, exp});
		@(posedge core_clk_i);
	endtask : rd

	// Exp is {irq, pulse, valid, nmi, level, src}
	task automatic req(input logic [8:0] exp);
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk({7'h00, irq_o, nmi_pulse_o, req_valid_o, req_nmi_o, req_level_o, req_src_o},
			{7'h00, exp});
		@(posedge core_clk_i);
	endtask : req

	task automatic end_sim;
		if (n_mismatch == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		rd(8'h00, 8'h09);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wr(8'h01, pat[i]);
			wr(8'h02, ~pat[i]);
			rd(8'h01, pat[i]);
			rd(8'h02, ~pat[i]);
		end
		wr(8'h01, 8'h08);
		wr(8'h02, 8'h02);
		wr(8'h04, 8'h01);
		src_req_i <= 16'h020a;
		req(9'h053);
		src_req_i <= 16'h0202;
		req(9'h059);
		src_req_i <= 16'h0002;
		req(9'h041);
		wr(8'h00, 8'h00);
		cpu_sec_bit_i <= 1'b1;
		req(9'h000);
		src_req_i <= 16'h0202;
		req(9'h059);
		wr(8'h00, 8'h08);
		src_req_i <= 16'h0002;
		req(9'h041);
		nmi_i <= 1'b0;
		req(9'h1e0);
		cpu_mask_i <= 1'b1;
		req(9'h160);
		ack_en <= 1'b1;
		for (int i = 0; i < 20 && req_valid_o; i++) @(posedge core_clk_i);
		req(9'h100);
		rd(8'h03, 8'h03);
		wr(8'h03, 8'h01);
		rd(8'h03, 8'h02);
		req(9'h000);
		ack_wait <= 4'h0;
		wr(8'h00, 8'h0c);
		nmi_i <= 1'b1;
		req(9'h1e0);
		wr(8'h04, 8'h00);
		nmi_i <= 1'b0;
		req(9'h000);
		end_sim();
	end
endmodule : iepc_ctrl_bench
